/* File: ubg_cfg.svh */
// register offsets, field positions, reset values and divider constants
`ifndef UBG_CFG_SVH
`define UBG_CFG_SVH

`define UBG_OFS_CTRL     8'h00
`define UBG_OFS_FRAC     8'h04
`define UBG_OFS_RLD_LO   8'h08
`define UBG_OFS_RLD_HI   8'h0c
`define UBG_OFS_LEGACY   8'h10
`define UBG_OFS_STATUS   8'h14
`define UBG_OFS_T2CNT    8'h18
`define UBG_OFS_TXCNT    8'h1c

`define UBG_SEL_BIT      7
`define UBG_DIV_HI       2
`define UBG_DIV_LO       0
`define UBG_RATE_DOUBLING_BIT_BIT     0
`define UBG_TXT2_BIT     1
`define UBG_RXT2_BIT     2
`define UBG_T2RUN_BIT    3

`define UBG_CTRL_RST     8'h00
`define UBG_FRAC_RST     8'h00
`define UBG_RLD_RST      8'h00
`define UBG_LEGACY_RST   8'h00

`define UBG_FRAC_BASE    9'h040
`define UBG_FRAC_STEP    9'h020
`define UBG_T2_PRE_LAST  1'h1

`endif

/* File: ubg_pkg.sv */
// types shared by the baud generator modules
package ubg_pkg;
  typedef enum logic [1:0] {
    UBG_IDLE = 2'h0,
    UBG_ACK  = 2'h1
  } ubg_apb_state_t;

  typedef enum logic [1:0] {
    UBG_SRC_T1  = 2'h0,
    UBG_SRC_T2  = 2'h1,
    UBG_SRC_DED = 2'h2
  } ubg_src_t;
endpackage

/* File: ubg_src_if.sv */
// configuration and ticks between the control logic and the two rate sources
interface ubg_src_if;
  logic        ded_sel;
  logic [2:0]  prescale;
  logic [7:0]  frac;
  logic        ded_tick;
  logic        t2_run;
  logic [15:0] reload;
  logic        t2_ovf;
  logic [15:0] t2_count;

  modport ctl (output ded_sel, prescale, frac, t2_run, reload, input ded_tick, t2_ovf, t2_count);
  modport ded (input ded_sel, prescale, frac, output ded_tick);
  modport rel (input t2_run, reload, output t2_ovf, t2_count);
endinterface

/* File: ubg_frac_timer.sv */
// dedicated baud timer: power-of-two prescaler followed by a fractional divider
`include "ubg_cfg.svh"
module ubg_frac_timer
  import ubg_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  ubg_src_if.ded    src
);
  logic [6:0] pre_cnt;
  logic [6:0] pre_last;
  logic       pre_tick;
  logic [8:0] acc;
  logic [8:0] modulus;
  logic [8:0] next_acc;

  // own counters only, so the general timers stay free
  assign pre_last = 7'((8'h01 << src.prescale) - 8'h01);
  // lowering the prescaler mid-count must not stall until the counter wraps
  assign pre_tick = (pre_cnt >= pre_last);
  assign modulus  = `UBG_FRAC_BASE + {1'b0, src.frac};
  assign next_acc = acc + `UBG_FRAC_STEP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 7'h00;
    end else if (!src.ded_sel || pre_tick) begin
      pre_cnt <= 7'h00;
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // adds 32 per prescaled tick modulo (frac+64): sixteen ticks per bit on average
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc          <= 9'h000;
      src.ded_tick <= 1'b0;
    end else if (!src.ded_sel) begin
      acc          <= 9'h000;
      src.ded_tick <= 1'b0;
    end else if (pre_tick && next_acc >= modulus) begin
      acc          <= next_acc - modulus;
      src.ded_tick <= 1'b1;
    end else if (pre_tick) begin
      acc          <= next_acc;
      src.ded_tick <= 1'b0;
    end else begin
      src.ded_tick <= 1'b0;
    end
  end
endmodule

/* File: ubg_reload_timer.sv */
// 16-bit auto-reload timer counting every second core clock
`include "ubg_cfg.svh"
module ubg_reload_timer
  import ubg_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  ubg_src_if.rel    src
);
  logic pre;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= 1'b0;
    end else if (!src.t2_run) begin
      pre <= 1'b0;
    end else begin
      pre <= ~pre;
    end
  end

  // overflow period is 2*(65536-reload) core clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src.t2_count <= 16'h0000;
      src.t2_ovf   <= 1'b0;
    end else if (!src.t2_run) begin
      src.t2_count <= src.reload;
      src.t2_ovf   <= 1'b0;
    end else if (pre == `UBG_T2_PRE_LAST && src.t2_count == 16'hffff) begin
      src.t2_count <= src.reload;
      src.t2_ovf   <= 1'b1;
    end else if (pre == `UBG_T2_PRE_LAST) begin
      src.t2_count <= src.t2_count + 16'h0001;
      src.t2_ovf   <= 1'b0;
    end else begin
      src.t2_ovf   <= 1'b0;
    end
  end
endmodule

/* File: ubg_baud_gen.sv */
// uart baud generator for the variable-rate modes, with its apb register file
// Overview of operation
// - reload source gives core/(32*(65536-reload))
// - select bit forces dedicated timer, ignores legacy
// - select clear keeps legacy timer1/timer2 scheme
// - prescaler field divides by two to value
// - dedicated rate is 2*core/(2^div*(frac+64))
// - every source runs from the core clock
// - range 6 to 393216 within 0.8%
// - dedicated timer independent of general timers
// - per-direction timer2 select, rates may differ
`include "ubg_cfg.svh"
module ubg_baud_gen
  import ubg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  uart_mode,
  input  wire logic        t1_overflow,
  output logic             tx_baud_x16,
  output logic             rx_baud_x16
);
  ubg_src_if src ();

  ubg_apb_state_t state;
  ubg_apb_state_t next_state;
  logic [7:0]     dedicated_baud_control;
  logic [7:0]     fractional_divide_value;
  logic [7:0]     reload_timer_low_byte;
  logic [7:0]     reload_timer_high_byte;
  logic [7:0]     legacy_ctrl;
  logic [15:0]    tx_tick_count;
  logic           t1_half;
  logic           t1_tick;
  logic           tx_src_tick;
  logic           rx_src_tick;
  logic           variable_mode;
  logic           access;
  logic           wr;
  logic           hit;
  logic [31:0]    rd_mux;
  // write strobes and the answer condition
  logic           wr_ctrl;
  logic           wr_frac;
  logic           wr_rld_lo;
  logic           wr_rld_hi;
  logic           wr_legacy;
  logic           wr_txcnt;
  logic           answer;
  ubg_src_t       tx_src;
  ubg_src_t       rx_src;

  // pclk is the pll-derived core clock; no crystal path reaches here
  ubg_frac_timer u_frac (
    .pclk    (pclk),
    .presetn (presetn),
    .src     (src)
  );

  ubg_reload_timer u_reload (
    .pclk    (pclk),
    .presetn (presetn),
    .src     (src)
  );

  assign src.ded_sel  = dedicated_baud_control[`UBG_SEL_BIT];
  assign src.prescale = dedicated_baud_control[`UBG_DIV_HI:`UBG_DIV_LO];
  assign src.frac     = fractional_divide_value;
  assign src.reload   = {reload_timer_high_byte, reload_timer_low_byte};
  assign src.t2_run   = legacy_ctrl[`UBG_T2RUN_BIT];

  // apb handshake: one wait state, pready straight from a flop
  assign access = psel && penable;
  assign wr     = access && pwrite && pready;

  // one strobe per register keeps every write condition in one place
  assign wr_ctrl   = wr && (paddr == `UBG_OFS_CTRL);
  assign wr_frac   = wr && (paddr == `UBG_OFS_FRAC);
  assign wr_rld_lo = wr && (paddr == `UBG_OFS_RLD_LO);
  assign wr_rld_hi = wr && (paddr == `UBG_OFS_RLD_HI);
  assign wr_legacy = wr && (paddr == `UBG_OFS_LEGACY);
  assign wr_txcnt  = wr && (paddr == `UBG_OFS_TXCNT);
  assign answer    = (state == UBG_IDLE) && access;

  always_comb begin
    next_state = state;
    case (state)
      UBG_IDLE: begin
        if (access) begin
          next_state = UBG_ACK;
        end
      end
      UBG_ACK: begin
        next_state = UBG_IDLE;
      end
      default: begin
        next_state = UBG_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= UBG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= answer;
    end
  end

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `UBG_OFS_CTRL: begin
        rd_mux = {24'h000000, dedicated_baud_control[`UBG_SEL_BIT], 4'h0,
                  dedicated_baud_control[`UBG_DIV_HI:`UBG_DIV_LO]};
      end
      `UBG_OFS_FRAC: begin
        rd_mux = {24'h000000, fractional_divide_value};
      end
      `UBG_OFS_RLD_LO: begin
        rd_mux = {24'h000000, reload_timer_low_byte};
      end
      `UBG_OFS_RLD_HI: begin
        rd_mux = {24'h000000, reload_timer_high_byte};
      end
      `UBG_OFS_LEGACY: begin
        rd_mux = {28'h0000000, legacy_ctrl[3:0]};
      end
      `UBG_OFS_STATUS: begin
        rd_mux = {26'h0000000, variable_mode, t1_half, rx_src, tx_src};
      end
      `UBG_OFS_T2CNT: begin
        rd_mux = {16'h0000, src.t2_count};
      end
      `UBG_OFS_TXCNT: begin
        rd_mux = {16'h0000, tx_tick_count};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // read data stands only in the answer cycle, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (answer && !pwrite) begin
      prdata <= rd_mux;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= answer && !hit;
    end
  end

  // writes land only at the completing edge; unused control bits are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dedicated_baud_control <= `UBG_CTRL_RST;
    end else if (wr_ctrl) begin
      dedicated_baud_control <= {pwdata[`UBG_SEL_BIT], 4'h0, pwdata[`UBG_DIV_HI:`UBG_DIV_LO]};
    end
  end

  // software computes frac and prescale itself; hardware takes them as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fractional_divide_value <= `UBG_FRAC_RST;
    end else if (wr_frac) begin
      fractional_divide_value <= pwdata[7:0];
    end
  end

  // the reload bytes are written one at a time; the timer takes them at its next reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_timer_low_byte <= `UBG_RLD_RST;
    end else if (wr_rld_lo) begin
      reload_timer_low_byte <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_timer_high_byte <= `UBG_RLD_RST;
    end else if (wr_rld_hi) begin
      reload_timer_high_byte <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      legacy_ctrl <= `UBG_LEGACY_RST;
    end else if (wr_legacy) begin
      legacy_ctrl <= {4'h0, pwdata[3:0]};
    end
  end

  // timer1 halving: with doubling clear a bit spans 32 overflows, else 16
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_half <= 1'b0;
    end else if (t1_overflow) begin
      t1_half <= ~t1_half;
    end
  end

  assign t1_tick = t1_overflow && (legacy_ctrl[`UBG_RATE_DOUBLING_BIT_BIT] || t1_half);

  // source choice per direction; the dedicated timer overrides all legacy bits
  always_comb begin
    if (src.ded_sel) begin
      tx_src = UBG_SRC_DED;
    end else begin
      tx_src = legacy_ctrl[`UBG_TXT2_BIT] ? UBG_SRC_T2 : UBG_SRC_T1;
    end
  end

  always_comb begin
    if (src.ded_sel) begin
      rx_src = UBG_SRC_DED;
    end else begin
      rx_src = legacy_ctrl[`UBG_RXT2_BIT] ? UBG_SRC_T2 : UBG_SRC_T1;
    end
  end

  always_comb begin
    case (tx_src)
      UBG_SRC_DED: tx_src_tick = src.ded_tick;
      UBG_SRC_T2:  tx_src_tick = src.t2_ovf;
      default:     tx_src_tick = t1_tick;
    endcase
  end

  always_comb begin
    case (rx_src)
      UBG_SRC_DED: rx_src_tick = src.ded_tick;
      UBG_SRC_T2:  rx_src_tick = src.t2_ovf;
      default:     rx_src_tick = t1_tick;
    endcase
  end

  // fixed-rate modes 0 and 2 use their own dividers elsewhere
  assign variable_mode = uart_mode[0];

  // a source switch can line up two ticks; each output stays a lone pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_baud_x16 <= 1'b0;
    end else begin
      tx_baud_x16 <= variable_mode && tx_src_tick && !tx_baud_x16;
    end
  end

  // receive side may run from another source than transmit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_baud_x16 <= 1'b0;
    end else begin
      rx_baud_x16 <= variable_mode && rx_src_tick && !rx_baud_x16;
    end
  end

  // running count of transmit ticks lets software check the rate; a write to its offset 0x1c clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_tick_count <= 16'h0000;
    end else if (wr_txcnt) begin
      tx_tick_count <= 16'h0000;
    end else if (tx_baud_x16) begin
      tx_tick_count <= tx_tick_count + 16'h0001;
    end
  end
endmodule

/* File: ubg_baud_gen_props.sv */
// port assertions for the baud generator
module ubg_baud_gen_props
  import ubg_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  uart_mode,
  input wire logic        tx_baud_x16,
  input wire logic        rx_baud_x16
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && !penable ##1 psel && penable && !pready;
  endsequence
  a_ready_wait: assert property (s_access |=> pready) else $error("no answer after one wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata outside answer");
  a_tx_single: assert property (tx_baud_x16 |=> !tx_baud_x16) else $error("tx tick too long");
  a_rx_single: assert property (rx_baud_x16 |=> !rx_baud_x16) else $error("rx tick too long");
  // three cycles: a source tick already in flight may still leave
  a_mode_gate: assert property (!uart_mode[0] [*3] |-> !tx_baud_x16 && !rx_baud_x16)
    else $error("tick in fixed mode");
  a_reset_quiet: assert property ($rose(presetn) |-> !pready && !tx_baud_x16 && !rx_baud_x16)
    else $error("output after reset");
endmodule
bind ubg_baud_gen ubg_baud_gen_props ubg_baud_gen_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .uart_mode(uart_mode),
  .tx_baud_x16(tx_baud_x16), .rx_baud_x16(rx_baud_x16));

/* File: ubg_uart_far.sv */
// uart shift logic model: counts 16x ticks per direction
module ubg_uart_far (
  input wire logic pclk,
  input wire logic tx_baud_x16,
  input wire logic rx_baud_x16
);
  timeunit 1ns;
  timeprecision 1ps;
  int tx_ticks = 0;
  int rx_ticks = 0;
  // directions counted apart since their sources may differ
  always @(posedge pclk) begin
    tx_ticks <= tx_ticks + int'(tx_baud_x16 === 1'b1);
    rx_ticks <= rx_ticks + int'(rx_baud_x16 === 1'b1);
  end
endmodule

/* File: ubg_baud_gen_tb.sv */
// testbench for the baud generator
module ubg_baud_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, t1_overflow = 0;
  logic        pready, pslverr, tx_baud_x16, rx_baud_x16, err;
  logic [7:0]  paddr = 8'h00;
  logic [1:0]  uart_mode = 2'h1;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int          mismatches = 0, tests_run = 0, cyc = 0, t1_per = 0;

  ubg_baud_gen ubg_baud_gen_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .uart_mode(uart_mode), .t1_overflow(t1_overflow), .tx_baud_x16(tx_baud_x16), .rx_baud_x16(rx_baud_x16));
  ubg_uart_far ubg_uart_far_i (.pclk(pclk), .tx_baud_x16(tx_baud_x16), .rx_baud_x16(rx_baud_x16));

  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    t1_overflow <= t1_per != 0 && cyc % t1_per == 0;
    if (cyc == 30000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one idle cycle after each transfer keeps psel single-driven per step
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // tick counts over n cycles, one tick of slack for window phase
  task automatic rate(string what, int n, int etx, int erx);
    int tx0, rx0;
    tx0 = ubg_uart_far_i.tx_ticks;
    rx0 = ubg_uart_far_i.rx_ticks;
    repeat (n) @(posedge pclk);
    tx0 = ubg_uart_far_i.tx_ticks - tx0 - etx;
    rx0 = ubg_uart_far_i.rx_ticks - rx0 - erx;
    chk({what, " tx"}, 32'(tx0 >= -1 && tx0 <= 1), 32'h1);
    chk({what, " rx"}, 32'(rx0 >= -1 && rx0 <= 1), 32'h1);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      apb(0, 8'(a * 4), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(0, 8'h20, 32'h0);
    chk("unmapped error", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1, 8'h00, 32'hff);
    apb(0, 8'h00, 32'h0);
    chk("control fields", rd, 32'h87);
    apb(1, 8'h00, 32'h0);
    apb(1, 8'h08, 32'hf0);
    apb(1, 8'h0c, 32'hff);
    t1_per = 4;
    apb(1, 8'h10, 32'h0b);
    rate("legacy split", 640, 20, 160);
    apb(0, 8'h14, 32'h0);
    chk("status split", rd & 32'h2f, 32'h21);
    apb(1, 8'h10, 32'h0a);
    rate("legacy halved", 640, 20, 80);
    apb(1, 8'h10, 32'h0f);
    apb(1, 8'h00, 32'h80);
    rate("override", 640, 320, 320);
    apb(0, 8'h14, 32'h0);
    chk("status override", rd & 32'h2f, 32'h2a);
    for (int d = 0; d < 8; d++) begin
      apb(1, 8'h00, 32'h80 | d);
      rate("prescaler", 2048, 1024 >> d, 1024 >> d);
    end
    apb(1, 8'h04, 32'h2d);
    apb(0, 8'h04, 32'h0);
    chk("fraction", rd, 32'h2d);
    apb(1, 8'h00, 32'h80);
    rate("fractional", 2180, 640, 640);
    uart_mode <= 2'h2;
    apb(1, 8'h1c, 32'h0);
    rate("fixed mode", 640, 0, 0);
    apb(0, 8'h1c, 32'h0);
    chk("tx count clear", rd, 32'h0);
    wrap_up();
  end
endmodule
